// ### design/timer_channel.sv
// One 16-bit counter channel with binary or decimal counting
`timescale 1ns/100ps
`default_nettype none
module timer_channel
   import timer_pkg::*;
(
   input wire logic clk_in, // system clock
   input wire logic rst_n_in, // sync reset, active low
   input wire logic [2:0] func_in, // selected function
   input wire logic bcd_in, // 1: decimal counting
   input wire logic load_in, // load pulse
   input wire logic [15:0] load_value_in, // count N
   input wire logic tick_in, // count enable pulse
   input wire logic gate_in, // gate level
   input wire logic trig_in, // trigger rising-edge pulse
   input wire logic sw_trig_in, // software trigger pulse
   output logic [15:0] count_out, // live count
   output logic out_out, // channel output
   output logic tc_out // terminal count pulse
);
   typedef struct packed {
      logic [15:0] count;
      logic [15:0] reload;
      logic out;
      logic armed;
      logic tc;
   } ch_state_t;

   ch_state_t s_q, s_d;
   logic [15:0] dec;
   logic zero_next;

   // Decimal decrement per nibble, wraps 0000 to 9999
   function automatic logic [15:0] bcd_dec(input logic [15:0] v);
      logic [15:0] r;
      logic borrow;
      r = v;
      borrow = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (borrow) begin
            if (v[i*4 +: 4] == 4'h0) begin
               r[i*4 +: 4] = 4'h9;
            end else begin
               r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
               borrow = 1'b0;
            end
         end
      end
      return r;
   endfunction

   assign dec = bcd_in ? bcd_dec(s_q.count) : s_q.count - 16'h0001;
   assign zero_next = (dec == 16'h0000);

   always_comb begin
      s_d = s_q;
      s_d.tc = 1'b0;
      if (load_in) begin
         s_d.count = load_value_in;
         s_d.reload = load_value_in;
         // Interrupt-style functions start low so terminal count shows
         s_d.out = (func_in != FN_TC_IRQ) && (func_in != FN_EVENT);
         s_d.armed = (func_in != FN_ONE_SHOT) && (func_in != FN_HW_STROBE);
      end else begin
         if ((func_in == FN_ONE_SHOT) && (trig_in || sw_trig_in)) begin
            s_d.count = s_q.reload;
            s_d.out = 1'b0;
            s_d.armed = 1'b1;
         end else if ((func_in == FN_HW_STROBE) && trig_in) begin
            s_d.count = s_q.reload;
            s_d.out = 1'b1;
            s_d.armed = 1'b1;
         end else if (tick_in && gate_in && s_q.armed) begin
            s_d.count = dec;
            case (func_in)
               FN_TC_IRQ, FN_EVENT: begin
                  if (zero_next) begin
                     s_d.out = 1'b1;
                     s_d.tc = 1'b1;
                  end
               end
               FN_ONE_SHOT: begin
                  if (zero_next) begin
                     s_d.out = 1'b1;
                     s_d.tc = 1'b1;
                     s_d.armed = 1'b0;
                  end
               end
               FN_RATE: begin
                  s_d.out = 1'b1;
                  if (dec == 16'h0001) begin
                     s_d.out = 1'b0;
                  end else if (zero_next) begin
                     s_d.count = s_q.reload;
                     s_d.tc = 1'b1;
                  end
               end
               FN_SQUARE: begin
                  // high first half, low second half when counting binary
                  if (zero_next) begin
                     s_d.count = s_q.reload;
                     s_d.out = 1'b1;
                     s_d.tc = 1'b1;
                  end else if (dec == (s_q.reload >> 1)) begin
                     s_d.out = 1'b0;
                  end
               end
               FN_SW_STROBE, FN_HW_STROBE: begin
                  // low for one tick at N counts
                  s_d.out = 1'b1;
                  if (zero_next) begin
                     s_d.out = 1'b0;
                     s_d.tc = 1'b1;
                     s_d.armed = 1'b0;
                  end
               end
               default: begin
                  s_d.out = 1'b1;
               end
            endcase
         end else if (tick_in && !s_q.out &&
                      ((func_in == FN_SW_STROBE) ||
                       (func_in == FN_HW_STROBE))) begin
            s_d.out = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s_q <= '{count: COUNT_RESET, reload: COUNT_RESET,
                  out: 1'b0, armed: 1'b0, tc: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign count_out = s_q.count;
   assign out_out = s_q.out;
   assign tc_out = s_q.tc;
endmodule
`default_nettype wire

// ### design/timer_pkg.sv
// Shared constants for the three-channel interval timer block
package timer_pkg;
   localparam int CHANNELS = 3;
   localparam int COUNT_W = 16;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [1:0] BAUD_CHANNEL = 2'h2;
   // Function codes, one of seven per channel
   localparam logic [2:0] FN_TC_IRQ = 3'h0;
   localparam logic [2:0] FN_ONE_SHOT = 3'h1;
   localparam logic [2:0] FN_RATE = 3'h2;
   localparam logic [2:0] FN_SQUARE = 3'h3;
   localparam logic [2:0] FN_SW_STROBE = 3'h4;
   localparam logic [2:0] FN_HW_STROBE = 3'h5;
   localparam logic [2:0] FN_EVENT = 3'h6;
   localparam logic [2:0] FN_RESET = FN_TC_IRQ;
   // Route strap field positions
   localparam int ROUTE_IRQ_BIT = 0;
   localparam int ROUTE_PORT_BIT = 1;
   localparam int ROUTE_EXTCLK_BIT = 2;
   localparam int ROUTE_PORTGATE_BIT = 3;
endpackage

// ### design/interval_timers_baud_clock.sv
// Three independent interval timers; channel two makes the bit-rate clock
// Notes on behaviour
// - Three independent 16-bit timers; only channels 0 and 1 can count external events
// - Each channel counts binary or decimal
// - Two general channels with strap-routed gates
// - General outputs routed to interrupt and port
// - Third channel makes the serial bit clock
// - Host picks one of seven functions per channel
// - Host reads any live count anytime
// - Terminal count raises an interrupt request
// - One-shot low on trigger, high at end
// - Rate generator: one low tick per N
// - Square wave: half high, half low when counting binary
`timescale 1ns/100ps
`default_nettype none
module interval_timers_baud_clock
   import timer_pkg::*;
(
   input wire logic clk_in, // system clock, 10 MHz
   input wire logic rst_n_in, // sync reset, active low
   input wire logic ref_tick_in, // reference clock tick pulse
   input wire logic [1:0] cfg_chan_in, // channel being configured
   input wire logic cfg_we_in, // function/mode write strobe
   input wire logic [2:0] cfg_func_in, // function code
   input wire logic cfg_bcd_in, // 1: decimal counting
   input wire logic load_we_in, // count load strobe
   input wire logic [15:0] load_value_in, // count N
   input wire logic sw_trig_in, // software trigger pulse
   input wire logic [1:0] rd_chan_in, // channel to read
   output logic [15:0] rd_count_out, // read count, one cycle late
   input wire logic [3:0] route0_in, // routing straps, channel 0
   input wire logic [3:0] route1_in, // routing straps, channel 1
   input wire logic [1:0] ext_gate_in, // external gate levels
   input wire logic [1:0] ext_event_in, // external event/trigger levels
   input wire logic [1:0] port_bit_in, // parallel-port gate bits
   output logic [1:0] irq_out, // interrupt request levels
   output logic [1:0] port_out, // outputs to port terminations
   output logic baud_clk_out // serial bit-rate clock
);
   typedef struct packed {
      logic [CHANNELS-1:0][2:0] func;
      logic [CHANNELS-1:0] bcd;
      logic [1:0] ev_prev;
      logic [15:0] rd;
      logic [1:0] irq;
      logic [1:0] port;
      logic baud;
   } top_state_t;

   top_state_t t_q, t_d;
   logic [CHANNELS-1:0] ld, tick, gate, trig, ch_out;
   logic [CHANNELS-1:0][15:0] cnt;
   logic [1:0][3:0] route;
   logic [1:0] ev_rise;

   assign route[0] = route0_in;
   assign route[1] = route1_in;
   assign ev_rise = ext_event_in & ~t_q.ev_prev;

   // strap-selected clock, gate and trigger sources
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         tick[i] = route[i][ROUTE_EXTCLK_BIT] ? ev_rise[i] : ref_tick_in;
         gate[i] = route[i][ROUTE_PORTGATE_BIT] ? port_bit_in[i]
                                                : ext_gate_in[i];
         trig[i] = route[i][ROUTE_EXTCLK_BIT] ? 1'b0 : ev_rise[i];
      end
      tick[BAUD_CHANNEL] = ref_tick_in;
      gate[BAUD_CHANNEL] = 1'b1;
      trig[BAUD_CHANNEL] = 1'b0;
   end

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_ch
         assign ld[g] = load_we_in && (cfg_chan_in == 2'(g));
         timer_channel u_ch (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .func_in(t_q.func[g]),
            .bcd_in(t_q.bcd[g]),
            .load_in(ld[g]),
            .load_value_in(load_value_in),
            .tick_in(tick[g]),
            .gate_in(gate[g]),
            .trig_in(trig[g]),
            .sw_trig_in(sw_trig_in && (cfg_chan_in == 2'(g))),
            .count_out(cnt[g]),
            .out_out(ch_out[g]),
            .tc_out()
         );
      end
   endgenerate

   always_comb begin
      t_d = t_q;
      t_d.ev_prev = ext_event_in;
      // function applied to addressed channel only
      if (cfg_we_in && (cfg_chan_in < 2'(CHANNELS)) &&
          (cfg_func_in <= FN_EVENT)) begin
         t_d.func[cfg_chan_in] = cfg_func_in;
         t_d.bcd[cfg_chan_in] = cfg_bcd_in;
      end
      // live count readable at any time
      t_d.rd = (rd_chan_in < 2'(CHANNELS)) ? cnt[rd_chan_in] : 16'h0000;
      for (int i = 0; i < 2; i++) begin
         t_d.irq[i] = route[i][ROUTE_IRQ_BIT] & ch_out[i];
         t_d.port[i] = route[i][ROUTE_PORT_BIT] & ch_out[i];
      end
      // channel two drives the bit clock
      t_d.baud = ch_out[BAUD_CHANNEL];
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         t_q <= '{func: {CHANNELS{FN_RESET}}, bcd: '0, ev_prev: 2'h0,
                  rd: COUNT_RESET, irq: 2'h0, port: 2'h0, baud: 1'b0};
      end else begin
         t_q <= t_d;
      end
   end

   assign rd_count_out = t_q.rd;
   assign irq_out = t_q.irq;
   assign port_out = t_q.port;
   assign baud_clk_out = t_q.baud;
endmodule
`default_nettype wire

// ### verif/timer_properties.sv
// Port checker for the interval timer block
`timescale 1ns/100ps
`default_nettype none
module timer_properties
   import timer_pkg::*;
(
   input wire logic clk_in, rst_n_in, ref_tick_in, cfg_we_in,
   input wire logic load_we_in, sw_trig_in, baud_clk_out,
   input wire logic [1:0] cfg_chan_in, rd_chan_in, irq_out, port_out,
   input wire logic [3:0] route0_in, route1_in,
   input wire logic [15:0] load_value_in, rd_count_out
);
   // Anything that may move the bit clock
   logic cause;
   assign cause = ref_tick_in | load_we_in | cfg_we_in | sw_trig_in;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   AST_RD_UNUSED: assert property (rd_chan_in == 2'h3 |=>
      rd_count_out == 16'h0000) else $error("unused channel read not zero");
   AST_LOAD_READ: assert property (load_we_in && cfg_chan_in != 2'h3 &&
      rd_chan_in == cfg_chan_in ##1 $stable(rd_chan_in) |=>
      rd_count_out == $past(load_value_in, 2)) else $error("load not read");
   AST_IRQ0_ROUTE: assert property (irq_out[0] |->
      $past(route0_in[0])) else $error("irq 0 without its strap");
   AST_IRQ1_ROUTE: assert property (irq_out[1] |->
      $past(route1_in[0])) else $error("irq 1 without its strap");
   AST_PORT1_OFF: assert property (!$past(route1_in[1]) |->
      !port_out[1]) else $error("port 1 driven without its strap");
   AST_AGREE0: assert property ($past(route0_in[1:0]) == 2'h3 |->
      irq_out[0] == port_out[0]) else $error("channel 0 routes differ");
   AST_AGREE1: assert property ($past(route1_in[1:0]) == 2'h3 |->
      irq_out[1] == port_out[1]) else $error("channel 1 routes differ");
   AST_BAUD_CAUSE: assert property ($changed(baud_clk_out) |->
      $past(cause, 2) || $past(cause, 3)) else $error("bit clock moved alone");
endmodule
bind interval_timers_baud_clock timer_properties chk_i (.clk_in, .rst_n_in,
   .ref_tick_in, .cfg_chan_in, .cfg_we_in, .load_we_in, .load_value_in,
   .sw_trig_in, .rd_chan_in, .rd_count_out, .route0_in, .route1_in,
   .irq_out, .port_out, .baud_clk_out);
`default_nettype wire

// ### verif/baud_partner.sv
// Far side: reference tick source and serial bit clock monitor
`timescale 1ns/100ps
`default_nettype none
module baud_partner #(
   parameter int TICK_DIV = 2 // clocks per reference tick
) (
   input wire logic clk_in, // system clock
   input wire logic run_in, // tick source on
   input wire logic baud_in, // bit clock from block
   output logic tick_out, // one-cycle reference tick
   output int low_out, // last low time, clocks
   output int period_out // last period, clocks
);
   int div = 0;
   int low_run = 0;
   int per_run = 0;
   logic prev = 1'b0;
   // serial end times the bit clock
   always @(posedge clk_in) begin
      prev <= baud_in;
      tick_out <= run_in && div == TICK_DIV - 1;
      div <= (!run_in || div == TICK_DIV - 1) ? 0 : div + 1;
      if (baud_in && !prev) begin
         period_out <= per_run;
         low_out <= low_run;
         per_run <= 1;
         low_run <= 0;
      end else begin
         per_run <= per_run + 1;
         low_run <= low_run + (baud_in ? 0 : 1);
      end
   end
endmodule
`default_nettype wire

// ### verif/interval_timers_baud_clock_tb.sv
// Self-checking bench for the interval timer block
`timescale 1ns/100ps
`default_nettype none
module interval_timers_baud_clock_tb;
   import timer_pkg::*;
   logic clk_in = 1'b0, rst_n_in = 1'b0, m_tick = 1'b0, p_run = 1'b0;
   logic cfg_we_in = 1'b0, load_we_in = 1'b0, sw_trig_in = 1'b0;
   logic cfg_bcd_in = 1'b0, p_tick, baud_clk_out;
   logic [1:0] cfg_chan_in = 2'h0, rd_chan_in = 2'h3, ext_event_in = 2'h0;
   logic [1:0] ext_gate_in = 2'h3, port_bit_in = 2'h0, irq_out, port_out;
   logic [2:0] cfg_func_in = 3'h0;
   logic [3:0] route0_in = 4'h0, route1_in = 4'h0;
   logic [15:0] load_value_in = 16'h0000, rd_count_out;
   int low_t, per_t, miscompares = 0, n_compared = 0;
   wire ref_tick_in = m_tick | p_tick;
   always #50 clk_in = ~clk_in;
   interval_timers_baud_clock uut (.clk_in, .rst_n_in, .ref_tick_in,
      .cfg_chan_in, .cfg_we_in, .cfg_func_in, .cfg_bcd_in, .load_we_in,
      .load_value_in, .sw_trig_in, .rd_chan_in, .rd_count_out, .route0_in,
      .route1_in, .ext_gate_in, .ext_event_in, .port_bit_in, .irq_out,
      .port_out, .baud_clk_out);
   baud_partner #(.TICK_DIV(2)) far (.clk_in, .run_in(p_run),
      .baud_in(baud_clk_out), .tick_out(p_tick), .low_out(low_t),
      .period_out(per_t));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #10;
   endtask
   // Function first, so the load sets the right initial output
   task automatic setup(input logic [1:0] ch, input logic [2:0] f,
         input logic b, input logic [15:0] n);
      cfg_chan_in = ch;
      cfg_func_in = f;
      cfg_bcd_in = b;
      cfg_we_in = 1'b1;
      step(1);
      cfg_we_in = 1'b0;
      load_value_in = n;
      load_we_in = 1'b1;
      step(1);
      load_we_in = 1'b0;
   endtask
   // Gap after each tick lets outputs settle before a look
   task automatic tick(input int n);
      repeat (n) begin
         m_tick = 1'b1;
         step(1);
         m_tick = 1'b0;
         step(1);
      end
   endtask
   task automatic t_count;
      rd_chan_in = 2'h0;
      setup(2'h0, FN_TC_IRQ, 1'b1, 16'h0010);
      tick(1);
      chk(rd_count_out, 16'h0009);
      setup(2'h0, FN_TC_IRQ, 1'b0, 16'h0010);
      tick(1);
      chk(rd_count_out, 16'h000F);
   endtask
   task automatic t_tc;
      route0_in = 4'h1;
      setup(2'h0, FN_TC_IRQ, 1'b0, 16'h0002);
      tick(1);
      chk(16'(irq_out), 16'h0000);
      tick(1);
      chk(16'(irq_out), 16'h0001);
      chk(16'(port_out), 16'h0000);
      route0_in = 4'h3;
      tick(2);
      chk(16'(port_out), 16'h0001);
   endtask
   task automatic t_shot;
      route0_in = 4'h0;
      route1_in = 4'h3;
      setup(2'h1, FN_ONE_SHOT, 1'b0, 16'h0003);
      ext_event_in = 2'h2;
      step(3);
      chk(16'(irq_out), 16'h0000);
      tick(3);
      chk(16'(irq_out), 16'h0002);
      ext_event_in = 2'h0;
   endtask
   task automatic t_strobe;
      route1_in = 4'h0;
      route0_in = 4'h1;
      setup(2'h0, FN_SW_STROBE, 1'b0, 16'h0002);
      tick(1);
      chk(16'(irq_out), 16'h0001);
      tick(1);
      chk(16'(irq_out), 16'h0000);
      tick(1);
      chk(16'(irq_out), 16'h0001);
   endtask
   task automatic t_baud;
      setup(BAUD_CHANNEL, FN_RATE, 1'b0, 16'h0004);
      p_run = 1'b1;
      step(40);
      chk(16'(per_t), 16'h0008);
      chk(16'(low_t), 16'h0002);
      setup(BAUD_CHANNEL, FN_SQUARE, 1'b0, 16'h0004);
      step(40);
      chk(16'(per_t), 16'h0008);
      chk(16'(low_t), 16'h0004);
      p_run = 1'b0;
   endtask
   // One rising edge on the chosen event lines, then idle
   task automatic ev(input logic [1:0] m);
      ext_event_in = m;
      step(1);
      ext_event_in = 2'h0;
      step(1);
   endtask
   task automatic t_reset;
      rd_chan_in = 2'h2;
      rst_n_in = 1'b0;
      step(2);
      rst_n_in = 1'b1;
      step(2);
      chk(rd_count_out | 16'(irq_out) | 16'(port_out), 16'h0000);
      chk(16'(baud_clk_out), 16'h0000);
   endtask
   task automatic t_event;
      route0_in = 4'hD;
      port_bit_in = 2'h0;
      rd_chan_in = 2'h0;
      setup(2'h0, FN_EVENT, 1'b0, 16'h0003);
      ev(2'h1);
      chk(rd_count_out, 16'h0003);
      port_bit_in = 2'h1;
      ev(2'h1);
      ev(2'h1);
      tick(2);
      chk(rd_count_out, 16'h0001);
      chk(16'(irq_out), 16'h0000);
      ev(2'h1);
      chk(16'(irq_out), 16'h0001);
   endtask
   task automatic t_hw;
      route0_in = 4'h0;
      route1_in = 4'h1;
      rd_chan_in = 2'h1;
      setup(2'h1, FN_HW_STROBE, 1'b0, 16'h0002);
      tick(1);
      chk(rd_count_out, 16'h0002);
      chk(16'(irq_out), 16'h0002);
      ev(2'h2);
      tick(1);
      ev(2'h2);
      chk(rd_count_out, 16'h0002);
      tick(2);
      chk(16'(irq_out), 16'h0000);
      tick(1);
      chk(16'(irq_out), 16'h0002);
   endtask
   task automatic t_sw;
      setup(2'h1, FN_ONE_SHOT, 1'b0, 16'h0002);
      sw_trig_in = 1'b1;
      step(1);
      sw_trig_in = 1'b0;
      step(1);
      chk(16'(irq_out), 16'h0000);
      tick(2);
      chk(16'(irq_out), 16'h0002);
      // Code seven must be ignored, channel stays one-shot
      cfg_func_in = 3'h7;
      cfg_we_in = 1'b1;
      step(1);
      cfg_we_in = 1'b0;
      sw_trig_in = 1'b1;
      step(1);
      sw_trig_in = 1'b0;
      step(1);
      chk(16'(irq_out), 16'h0000);
   endtask
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk_in);
      miscompares++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge clk_in);
      #10;
      rst_n_in = 1'b1;
      step(2);
      chk(rd_count_out | 16'(irq_out) | 16'(port_out), 16'h0000);
      t_count();
      t_tc();
      t_shot();
      t_strobe();
      t_baud();
      t_reset();
      t_event();
      t_hw();
      t_sw();
      stop_test();
   end
endmodule
`default_nettype wire
